// >>> rtl/dcc_comparator_control.sv
// comparator control: avalon register slave, edge interrupts and wake flags
`timescale 1ns/1ps
`default_nettype none
`include "dcc_consts.svh"

// Summary of operation
// - two independent channels, each with enable, reference, irq enable and edge select
// - one hysteresis field for both channels; the latest write wins
// - hysteresis code of two bits selects 0, 10, 20 or 40 mV
// - each channel selects external pin, converter output or internal reference
// - enabling a channel also turns shared low-power mode on
// - low-power mode is one setting driven to both comparators
// - clearing one channel's enable leaves the other channel untouched
// - per-channel irq enable lets an event interrupt and also wake
// - edge select high triggers on rising above reference, low on falling below
// - thresholds include hysteresis, applied by the analogue core from the code
// - events go out on the system-controller interrupt line and, while asleep, on the wake request
// - status reads one live output bit per channel, 1 meaning above reference
// - wake flags per channel set on a wake event, held until read
// - reading the wake flags clears the ones the read returns
module dcc_comparator_control
	import dcc_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          rstn,
	input  wire logic [7:0]    avsAddress,
	input  wire logic          avsRead,
	input  wire logic          avsWrite,
	input  wire logic [31:0]   avsWriteData,
	input  wire logic [3:0]    avsByteEnable,
	output logic      [31:0]   avsReadData,
	output logic               avsWaitRequest,
	input  wire logic [1:0]    cmpOut,
	input  wire logic          sleepActive,
	output dcc_chan_cfg_t      cfgOne,
	output dcc_chan_cfg_t      cfgTwo,
	output dcc_hyst_t          hysteresisCode,
	output logic               lowPowerSelect,
	output logic               sysCtrlIrq,
	output logic               wakeRequest
);

	// ************************************************************
	// state
	// ************************************************************
	logic [1:0]    cmpMeta;
	logic [1:0]    cmpSync;
	logic [1:0]    cmpPrev;
	logic          sleepMeta;
	logic          sleepSync;
	logic [1:0]    wakeFlags;
	logic [1:0]    irqStatus;
	logic [1:0]    irqMask;
	logic [1:0]    outStatus;

	dcc_chan_cfg_t next_cfgOne;
	dcc_chan_cfg_t next_cfgTwo;
	dcc_hyst_t     next_hysteresisCode;
	logic          next_lowPowerSelect;
	logic [1:0]    next_wakeFlags;
	logic [1:0]    next_irqStatus;
	logic [1:0]    next_irqMask;
	logic [31:0]   next_avsReadData;
	logic          next_avsWaitRequest;
	logic          next_sysCtrlIrq;
	logic          next_wakeRequest;

	logic          request;
	logic          accept;
	logic          wrLow;
	logic [1:0]    event2;
	logic [1:0]    riseSeen;
	logic [1:0]    fallSeen;

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic dcc_chan_cfg_t cfg_from_word(input logic [31:0] w);
		dcc_chan_cfg_t c;
		c.enable           = w[`DCC_CFG_ENABLE];
		c.referenceSelect  = dcc_ref_sel_t'(w[`DCC_CFG_REF_HI:`DCC_CFG_REF_LO]);
		c.channelIrqEnable = w[`DCC_CFG_IRQ_EN];
		c.edgeSelectRising = w[`DCC_CFG_RISING];
		return c;
	endfunction : cfg_from_word

	function automatic logic [31:0] cfg_to_word(input dcc_chan_cfg_t c);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[`DCC_CFG_ENABLE]                = c.enable;
		w[`DCC_CFG_REF_HI:`DCC_CFG_REF_LO] = c.referenceSelect;
		w[`DCC_CFG_IRQ_EN]                = c.channelIrqEnable;
		w[`DCC_CFG_RISING]                = c.edgeSelectRising;
		return w;
	endfunction : cfg_to_word

	// ************************************************************
	// next-state logic
	// ************************************************************
	always_comb begin
		request  = avsRead | avsWrite;
		// a request is taken only at the edge where waitrequest is already low
		accept   = request & ~avsWaitRequest;
		wrLow    = accept & avsWrite & avsByteEnable[0];
		riseSeen = cmpSync & ~cmpPrev;
		fallSeen = ~cmpSync & cmpPrev;
		event2[`DCC_CH_ONE] = cfgOne.enable & cfgOne.channelIrqEnable &
			(cfgOne.edgeSelectRising ? riseSeen[`DCC_CH_ONE] : fallSeen[`DCC_CH_ONE]);
		event2[`DCC_CH_TWO] = cfgTwo.enable & cfgTwo.channelIrqEnable &
			(cfgTwo.edgeSelectRising ? riseSeen[`DCC_CH_TWO] : fallSeen[`DCC_CH_TWO]);

		next_cfgOne         = cfgOne;
		next_cfgTwo         = cfgTwo;
		next_hysteresisCode = hysteresisCode;
		next_lowPowerSelect = lowPowerSelect;
		next_irqMask        = irqMask;
		next_irqStatus      = irqStatus;
		next_wakeFlags      = wakeFlags;

		if (wrLow && avsAddress == `DCC_OFF_CFG_ONE) begin
			next_cfgOne = cfg_from_word(avsWriteData);
			if (avsWriteData[`DCC_CFG_ENABLE] && !cfgOne.enable) begin
				next_lowPowerSelect = 1'b1;
			end
		end else if (wrLow && avsAddress == `DCC_OFF_CFG_TWO) begin
			next_cfgTwo = cfg_from_word(avsWriteData);
			if (avsWriteData[`DCC_CFG_ENABLE] && !cfgTwo.enable) begin
				next_lowPowerSelect = 1'b1;
			end
		end else if (wrLow && avsAddress == `DCC_OFF_SHARED) begin
			next_hysteresisCode = dcc_hyst_t'(avsWriteData[`DCC_SH_HYST_HI:`DCC_SH_HYST_LO]);
			next_lowPowerSelect = avsWriteData[`DCC_SH_LOW_POWER];
		end else if (wrLow && avsAddress == `DCC_OFF_IRQ_STATUS) begin
			next_irqStatus = irqStatus & ~avsWriteData[1:0];
		end else if (wrLow && avsAddress == `DCC_OFF_IRQ_MASK) begin
			next_irqMask = avsWriteData[1:0];
		end

		if (accept && avsRead && avsAddress == `DCC_OFF_WAKE_FLAGS) begin
			// clear what the answer carries: a flag set after the data was
			// latched in the wait cycle would otherwise be lost unread
			next_wakeFlags = wakeFlags & ~avsReadData[1:0];
		end
		// set wins over a clear in the same cycle
		next_irqStatus = next_irqStatus | event2;
		next_wakeFlags = next_wakeFlags | (event2 & {2{sleepSync}});

		next_sysCtrlIrq  = |(next_irqStatus & next_irqMask);
		next_wakeRequest = sleepSync & |event2;

		// read data is latched in the cycle before the answer
		next_avsReadData = 32'h0000_0000;
		if (avsAddress == `DCC_OFF_CFG_ONE) begin
			next_avsReadData = cfg_to_word(cfgOne);
		end else if (avsAddress == `DCC_OFF_CFG_TWO) begin
			next_avsReadData = cfg_to_word(cfgTwo);
		end else if (avsAddress == `DCC_OFF_SHARED) begin
			next_avsReadData[`DCC_SH_HYST_HI:`DCC_SH_HYST_LO] = hysteresisCode;
			next_avsReadData[`DCC_SH_LOW_POWER]              = lowPowerSelect;
		end else if (avsAddress == `DCC_OFF_OUT_STATUS) begin
			next_avsReadData[1:0] = outStatus;
		end else if (avsAddress == `DCC_OFF_WAKE_FLAGS) begin
			next_avsReadData[1:0] = wakeFlags;
		end else if (avsAddress == `DCC_OFF_IRQ_STATUS) begin
			next_avsReadData[1:0] = irqStatus;
		end else if (avsAddress == `DCC_OFF_IRQ_MASK) begin
			next_avsReadData[1:0] = irqMask;
		end
		if (!(avsRead && avsWaitRequest)) begin
			next_avsReadData = avsReadData;
		end
		// one wait cycle, then one answer cycle, then waitrequest rises again
		next_avsWaitRequest = ~(request & avsWaitRequest);
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cmpMeta        <= 2'h0;
			cmpSync        <= 2'h0;
			cmpPrev        <= 2'h0;
			sleepMeta      <= 1'b0;
			sleepSync      <= 1'b0;
			outStatus      <= 2'h0;
			cfgOne         <= '0;
			cfgTwo         <= '0;
			hysteresisCode <= hyst_level_zero;
			lowPowerSelect <= `DCC_RST_LOW_POWER;
			irqMask        <= `DCC_RST_MASK;
			irqStatus      <= 2'h0;
			wakeFlags      <= 2'h0;
			avsReadData    <= 32'h0000_0000;
			avsWaitRequest <= 1'b1;
			sysCtrlIrq     <= 1'b0;
			wakeRequest    <= 1'b0;
		end else begin
			cmpMeta        <= cmpOut;
			cmpSync        <= cmpMeta;
			cmpPrev        <= cmpSync;
			sleepMeta      <= sleepActive;
			sleepSync      <= sleepMeta;
			outStatus      <= cmpSync;
			cfgOne         <= next_cfgOne;
			cfgTwo         <= next_cfgTwo;
			hysteresisCode <= next_hysteresisCode;
			lowPowerSelect <= next_lowPowerSelect;
			irqMask        <= next_irqMask;
			irqStatus      <= next_irqStatus;
			wakeFlags      <= next_wakeFlags;
			avsReadData    <= next_avsReadData;
			avsWaitRequest <= next_avsWaitRequest;
			sysCtrlIrq     <= next_sysCtrlIrq;
			wakeRequest    <= next_wakeRequest;
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking dccCb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	sequence enableOneWrite;
		wrLow && avsAddress == `DCC_OFF_CFG_ONE && avsWriteData[`DCC_CFG_ENABLE] && !cfgOne.enable;
	endsequence

	sequence wakeRead;
		accept && avsRead && avsAddress == `DCC_OFF_WAKE_FLAGS;
	endsequence

	sequence enableTwoWrite;
		wrLow && avsAddress == `DCC_OFF_CFG_TWO && avsWriteData[`DCC_CFG_ENABLE] && !cfgTwo.enable;
	endsequence

	// status read: latched in the wait cycle, answered in the next one
	sequence statusRead;
		avsRead && avsWaitRequest && avsAddress == `DCC_OFF_OUT_STATUS ##1 !avsWaitRequest;
	endsequence

	enable_low_power_a: assert property (enableOneWrite |=> lowPowerSelect && cfgOne.enable)
		else $error("enabling channel one did not select low power");
	other_channel_kept_a: assert property (wrLow && avsAddress == `DCC_OFF_CFG_ONE |=>
		cfgTwo == $past(cfgTwo))
		else $error("channel two changed on a channel one write");
	hyst_latest_a: assert property (wrLow && avsAddress == `DCC_OFF_SHARED |=>
		hysteresisCode == $past(avsWriteData[`DCC_SH_HYST_HI:`DCC_SH_HYST_LO]))
		else $error("hysteresis code not the last written");
	live_status_a: assert property (##4 outStatus == $past(cmpOut, 3))
		else $error("status does not follow synchronised output");
	rising_edge_irq_a: assert property (cfgOne.enable && cfgOne.channelIrqEnable &&
		cfgOne.edgeSelectRising && riseSeen[0] |=> irqStatus[0])
		else $error("rising event not flagged");
	wrong_edge_quiet_a: assert property (!event2[0] && !irqStatus[0] |=> !irqStatus[0])
		else $error("status set without selected edge");
	wake_clear_a: assert property (wakeRead ##0 event2 == 2'h0 |=>
		(wakeFlags & $past(avsReadData[1:0])) == 2'h0)
		else $error("wake flags not cleared by read");
	wake_hold_a: assert property (wakeFlags[`DCC_CH_TWO] &&
		!(accept && avsRead && avsAddress == `DCC_OFF_WAKE_FLAGS) |=> wakeFlags[`DCC_CH_TWO])
		else $error("wake flag dropped without a read");
	irq_line_a: assert property (|(irqStatus & irqMask) |-> ##[0:1] sysCtrlIrq)
		else $error("interrupt line low with unmasked status");
	wait_answer_a: assert property (request && avsWaitRequest |=> !avsWaitRequest)
		else $error("bus answer not given after one wait cycle");

	// second channel, shared setting, reference select, input sync, wake side, interrupt line and read side
	two_low_power_a: assert property (enableTwoWrite |=> lowPowerSelect && cfgTwo.enable)
		else $error("enabling channel two did not select low power");
	one_channel_kept_a: assert property (wrLow && avsAddress == `DCC_OFF_CFG_TWO |=>
		cfgOne == $past(cfgOne))
		else $error("channel one changed on a channel two write");
	shared_low_power_a: assert property (wrLow && avsAddress == `DCC_OFF_SHARED |=>
		lowPowerSelect == $past(avsWriteData[`DCC_SH_LOW_POWER]))
		else $error("low power setting not the last written");
	ref_select_a: assert property (wrLow && avsAddress == `DCC_OFF_CFG_ONE |=>
		cfgOne.referenceSelect == $past(avsWriteData[`DCC_CFG_REF_HI:`DCC_CFG_REF_LO]))
		else $error("reference select not the written value");
	falling_edge_irq_a: assert property (cfgTwo.enable && cfgTwo.channelIrqEnable &&
		!cfgTwo.edgeSelectRising && fallSeen[`DCC_CH_TWO] |=> irqStatus[`DCC_CH_TWO])
		else $error("falling event not flagged");
	sync_delay_a: assert property (riseSeen[`DCC_CH_ONE] |-> $past(cmpOut[`DCC_CH_ONE], 2))
		else $error("edge seen before the output passed two flops");
	wake_pulse_a: assert property (sleepSync && |event2 |=> wakeRequest)
		else $error("no wake request for an event in sleep");
	wake_flag_set_a: assert property (sleepSync && event2[`DCC_CH_ONE] |=>
		wakeFlags[`DCC_CH_ONE])
		else $error("wake flag not set by an event in sleep");
	awake_no_wake_a: assert property (!sleepSync && wakeFlags == 2'h0 |=> wakeFlags == 2'h0)
		else $error("wake flag set while awake");
	irq_line_low_a: assert property ((irqStatus & irqMask) == 2'h0 |-> !sysCtrlIrq)
		else $error("interrupt line high with no unmasked status");
	status_read_a: assert property (statusRead |->
		avsReadData == {30'h0, $past(outStatus)})
		else $error("status read does not carry the live outputs");

endmodule : dcc_comparator_control

`default_nettype wire

// >>> rtl/dcc_consts.svh
// register offsets, field positions and reset values of the comparator control block
`ifndef DCC_CONSTS_SVH
`define DCC_CONSTS_SVH

`define DCC_OFF_CFG_ONE     8'h00
`define DCC_OFF_CFG_TWO     8'h04
`define DCC_OFF_SHARED      8'h08
`define DCC_OFF_OUT_STATUS  8'h0C
`define DCC_OFF_WAKE_FLAGS  8'h10
`define DCC_OFF_IRQ_STATUS  8'h14
`define DCC_OFF_IRQ_MASK    8'h18

`define DCC_CFG_ENABLE      0
`define DCC_CFG_REF_LO      1
`define DCC_CFG_REF_HI      2
`define DCC_CFG_IRQ_EN      3
`define DCC_CFG_RISING      4
`define DCC_SH_HYST_LO      0
`define DCC_SH_HYST_HI      1
`define DCC_SH_LOW_POWER    2

`define DCC_CH_ONE          0
`define DCC_CH_TWO          1
`define DCC_NUM_CH          2

`define DCC_RST_LOW_POWER   1'h0
`define DCC_RST_MASK        2'h0

`endif

// >>> rtl/dcc_pkg.sv
// types shared by the comparator control block
`default_nettype none
package dcc_pkg;

	typedef enum logic [1:0] {
		ref_sel_external_pin  = 2'b00,
		ref_sel_converter_out = 2'b01,
		ref_sel_internal_ref  = 2'b10
	} dcc_ref_sel_t;

	typedef enum logic [1:0] {
		hyst_level_zero   = 2'b00,
		hyst_level_ten    = 2'b01,
		hyst_level_twenty = 2'b10,
		hyst_level_forty  = 2'b11
	} dcc_hyst_t;

	typedef struct packed {
		logic         edgeSelectRising;
		logic         channelIrqEnable;
		dcc_ref_sel_t referenceSelect;
		logic         enable;
	} dcc_chan_cfg_t;

endpackage : dcc_pkg

`default_nettype wire

// >>> tb/dcc_analog_model.sv
// behavioural model of the two comparator cores and the sleep controller
`timescale 1ns/1ps
`default_nettype none
module dcc_analog_model
	import dcc_pkg::*;
#(
	parameter int REF_MV = 500
)
(
	input  wire logic          clk,
	input  wire dcc_chan_cfg_t cfgOne,
	input  wire dcc_chan_cfg_t cfgTwo,
	input  wire dcc_hyst_t     hysteresisCode,
	input  var  int            sigOne,
	input  var  int            sigTwo,
	input  wire logic          sleepReq,
	output logic [1:0]         cmpOut,
	output logic               sleepActive
);
	int hyst;
	always_comb hyst = (hysteresisCode == hyst_level_forty) ? 40 : 10 * int'(hysteresisCode);

	function automatic logic nextOut(input logic cur, input dcc_chan_cfg_t c, input int s);
		if (!c.enable) return 1'b0;
		// converter and internal reference are off while asleep
		if (sleepReq && c.referenceSelect != ref_sel_external_pin) return cur;
		if (s > REF_MV + hyst) return 1'b1;
		if (s < REF_MV - hyst) return 1'b0;
		return cur;
	endfunction : nextOut

	initial cmpOut = 2'h0;
	initial sleepActive = 1'b0;
	always @(posedge clk) begin
		cmpOut[0] <= nextOut(cmpOut[0], cfgOne, sigOne);
		cmpOut[1] <= nextOut(cmpOut[1], cfgTwo, sigTwo);
		sleepActive <= sleepReq;
	end
endmodule : dcc_analog_model
`default_nettype wire

// >>> tb/dual_comparator_control_tb_top.sv
// self-checking bench of the comparator control block
`timescale 1ns/1ps
`default_nettype none
module dual_comparator_control_tb_top
	import dcc_pkg::*;
;
	localparam int REF = 500;
	logic          clk = 1'b0;
	logic          rstn = 1'b0;
	logic [7:0]    avsAddress = 8'h00;
	logic          avsRead = 1'b0;
	logic          avsWrite = 1'b0;
	logic [31:0]   avsWriteData = 32'h0;
	logic [3:0]    avsByteEnable = 4'hF;
	logic [31:0]   avsReadData, rd, rnd = 32'h8CAE;
	logic          avsWaitRequest, sysCtrlIrq, wakeRequest, lowPowerSelect, sleepActive;
	logic          sleepReq = 1'b0, ch, lp;
	logic [1:0]    cmpOut;
	dcc_chan_cfg_t cfgOne, cfgTwo, c;
	dcc_chan_cfg_t cfg [2] = '{default: '0};
	dcc_hyst_t     hysteresisCode;
	int            sigOne = 0, sigTwo = 0, miscompares = 0, cmpCount = 0, wakeCount = 0, w;

	dcc_comparator_control i_dcc_comparator_control (.clk(clk), .rstn(rstn),
		.avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
		.avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
		.avsWaitRequest(avsWaitRequest), .cmpOut(cmpOut), .sleepActive(sleepActive),
		.cfgOne(cfgOne), .cfgTwo(cfgTwo), .hysteresisCode(hysteresisCode),
		.lowPowerSelect(lowPowerSelect), .sysCtrlIrq(sysCtrlIrq), .wakeRequest(wakeRequest));
	dcc_analog_model #(.REF_MV(REF)) i_dcc_analog_model (.clk(clk), .cfgOne(cfgOne),
		.cfgTwo(cfgTwo), .hysteresisCode(hysteresisCode), .sigOne(sigOne), .sigTwo(sigTwo),
		.sleepReq(sleepReq), .cmpOut(cmpOut), .sleepActive(sleepActive));

	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		if (wakeRequest === 1'b1) wakeCount <= wakeCount + 1;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmpCount, miscompares);
		if (miscompares == 0 && cmpCount > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : summarize

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// request held until waitrequest is sampled low, then released a cycle apart
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] be);
		int n;
		n = 0;
		avsAddress <= a;
		avsWrite <= wr;
		avsRead <= !wr;
		avsWriteData <= d;
		avsByteEnable <= be;
		do begin
			@(posedge clk);
			n++;
		end while (avsWaitRequest !== 1'b0 && n < 20);
		rd = avsReadData;
		if (avsWaitRequest !== 1'b0) begin
			miscompares++;
			summarize();
		end
		avsWrite <= 1'b0;
		avsRead <= 1'b0;
		@(posedge clk);
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hF);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
		bus(1'b0, a, 32'h0, 4'hF);
		check(what, rd, exp);
	endtask : rdc

	task automatic waitIrq(input logic want);
		int n;
		n = 0;
		while (sysCtrlIrq !== want && n < 20) begin
			@(posedge clk);
			n++;
		end
		check("irq line", sysCtrlIrq, want);
		if (n >= 20) summarize();
	endtask : waitIrq

	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		bus(1'b1, 8'h1C, 32'hFF, 4'hF);
		for (int a = 0; a < 32; a += 4) rdc(a[7:0], 32'h0, "reset read");
		$display("reset test done");
		for (int h = 0; h < 4; h++) begin
			wr(8'h08, {29'h0, h[0], h[1:0]});
			check("hyst code", hysteresisCode, h[1:0]);
			check("low power", lowPowerSelect, h[0]);
			rdc(8'h08, {29'h0, h[0], h[1:0]}, "shared");
		end
		$display("shared test done");
		wr(8'h08, 32'h0);
		lp = 1'b0;
		// all configuration is done awake, the analogue regulator taken as on
		for (int i = 0; i < 24; i++) begin
			rnd = lfsr(rnd);
			c = dcc_chan_cfg_t'(rnd[4:0]);
			if (c[2:1] == 2'b11) c[2:1] = 2'b01;
			ch = rnd[5];
			if (c.enable && !cfg[ch].enable) lp = 1'b1;
			cfg[ch] = c;
			wr({5'h0, ch, 2'h0}, {27'h0, c});
			check("cfg one", cfgOne, cfg[0]);
			check("cfg two", cfgTwo, cfg[1]);
			check("low power", lowPowerSelect, lp);
			rdc({5'h0, ch, 2'h0}, {27'h0, c}, "cfg read");
		end
		bus(1'b1, 8'h00, 32'h1F, 4'hE);
		check("lane ignored", cfgOne, cfg[0]);
		$display("config test done");
		wr(8'h18, 32'h3);
		wr(8'h00, 32'h19);
		wr(8'h04, 32'h09);
		// channel two rises only once it is armed for falling edges
		sigTwo <= REF + 100;
		repeat (10) @(posedge clk);
		rdc(8'h14, 32'h0, "no rising on falling channel");
		sigOne <= REF + 100;
		waitIrq(1'b1);
		rdc(8'h14, 32'h1, "rising event");
		rdc(8'h0C, 32'h3, "live status");
		wr(8'h14, 32'h1);
		waitIrq(1'b0);
		sigOne <= REF - 100;
		sigTwo <= REF - 100;
		waitIrq(1'b1);
		rdc(8'h14, 32'h2, "falling event");
		rdc(8'h0C, 32'h0, "live status");
		wr(8'h18, 32'h0);
		waitIrq(1'b0);
		wr(8'h14, 32'h2);
		wr(8'h18, 32'h3);
		$display("edge test done");
		sigTwo <= REF + 100;
		repeat (10) @(posedge clk);
		rdc(8'h10, 32'h0, "no wake while awake");
		w = wakeCount;
		sleepReq <= 1'b1;
		repeat (4) @(posedge clk);
		sigOne <= REF + 100;
		sigTwo <= REF - 100;
		repeat (10) @(posedge clk);
		check("wake pulses", wakeCount - w, 1);
		sleepReq <= 1'b0;
		rdc(8'h10, 32'h3, "wake flags");
		rdc(8'h10, 32'h0, "wake after read");
		$display("wake test done");
		summarize();
	end
endmodule : dual_comparator_control_tb_top
`default_nettype wire
